// File: hw/cell_monitor_serial_command_decoder.sv
// Serial command decoder and output control of the cell monitor
`default_nettype none
// What this block does
// - Shift bits only while select is low
// - Sample one bit per rising shift clock, LSB first
// - Select rising copies shift register and acts
// - Upper three bits pick group; 110/111 ignored
// - Codes 0-3 cell voltage, 4-7 cell offset
// - Close matching upper and lower switch pair
// - FET bit low drives its output high
// - Reset drives all three FET outputs high
// - Mux 001 routes measurement, 0/2/3 ground
// - Grounded output stops detection, power save
// - Reset grounds output, opens detection switches
// - Regulator 0/3 is 3.3V, 2 5V, 1 off
// - Reset selects 3.3V regulator output
// - Charger present blocks power down
// - Power down holds all FET outputs high
// - Power down: discharge high, pulldown, regulator off
// - Balance 0 opens all, others close one
// - Balance switches accumulate over commands
// - Reset opens all balance switches
// - Discharge override drives discharge output high
// - Charge override drives charge and precharge high
// - Overrides win over serial FET settings
module cell_monitor_serial_command_decoder #(
  parameter int CMD_BITS = cell_monitor_pkg::CMD_WIDTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Serial command port
  input wire logic select_n,
  input wire logic shift_clock,
  input wire logic serial_data_in,
  // Direct FET overrides and charger sense
  input wire logic discharge_override_in,
  input wire logic charge_override_in,
  input wire logic charger_present_in,
  // FET drives
  output logic charge_fet_drive,
  output logic discharge_fet_drive,
  output logic precharge_fet_drive,
  // Measurement switches, index 0..4, and analog output control
  output logic [cell_monitor_pkg::SWITCHES-1:0] cell_switch_upper,
  output logic [cell_monitor_pkg::SWITCHES-1:0] cell_switch_lower,
  output logic mux_route_measurement,
  output logic detect_enable,
  // Regulator and power state
  output logic regulator_enable,
  output logic regulator_5v_sel,
  output logic power_down,
  output logic charger_pulldown,
  // Cell balance switches
  output logic [cell_monitor_pkg::CELLS-1:0] balance_switch,
  // Last latched command word
  output logic [cell_monitor_pkg::CMD_WIDTH-1:0] command_latch
);

  if (CMD_BITS != cell_monitor_pkg::CMD_WIDTH) begin : g_bad_cmd
    $error("Command decoder serves only six-bit commands");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling

  cell_monitor_pkg::pins_s pins_raw;
  cell_monitor_pkg::pins_s pins;
  logic shift_clock_prev;
  logic select_n_prev;

  assign pins_raw = '{select_n: select_n, shift_clock: shift_clock,
    serial_data_in: serial_data_in,
    discharge_override_in: discharge_override_in,
    charge_override_in: charge_override_in,
    charger_present_in: charger_present_in};

  pin_synchroniser #(
    .WIDTH($bits(cell_monitor_pkg::pins_s)),
    .RESET_VALUE(cell_monitor_pkg::PINS_IDLE)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .pins(pins_raw),
    .levels(pins)
  );

  // Data travels through the same stages as the clock, so setup holds
  wire shift_edge = pins.shift_clock && !shift_clock_prev;
  wire shift_take = shift_edge && !pins.select_n;
  wire cmd_strobe = pins.select_n && !select_n_prev;

  always_ff @(posedge clock) begin
    if (reset) begin
      shift_clock_prev <= 1'b0;
      select_n_prev <= 1'b1;
    end else begin
      shift_clock_prev <= pins.shift_clock;
      select_n_prev <= pins.select_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register: newest bit enters at the top, so after six bits D0
  // sits at bit 0; more than six edges simply keep the last six

  logic [CMD_BITS-1:0] shift_reg;
  wire [CMD_BITS-1:0] next_shift_reg =
    {pins.serial_data_in, shift_reg[CMD_BITS-1:1]};

  always_ff @(posedge clock) begin
    if (reset) begin
      shift_reg <= '0;
    end else if (shift_take) begin
      shift_reg <= next_shift_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  wire [2:0] group = shift_reg[cell_monitor_pkg::GROUP_MSB:
    cell_monitor_pkg::GROUP_LSB];
  wire [2:0] code = shift_reg[cell_monitor_pkg::CODE_MSB:
    cell_monitor_pkg::CODE_LSB];

  // While powered down only a regulator command is heard
  wire cmd_live = cmd_strobe && (!power_down
    || group == cell_monitor_pkg::GRP_REG);
  wire hit_reset = cmd_live && group == cell_monitor_pkg::GRP_RESET;
  wire hit_cell = cmd_live && group == cell_monitor_pkg::GRP_CELL_MON;
  wire hit_fet = cmd_live && group == cell_monitor_pkg::GRP_FET;
  wire hit_mux = cmd_live && group == cell_monitor_pkg::GRP_MUX;
  wire hit_reg = cmd_live && group == cell_monitor_pkg::GRP_REG;
  wire hit_bal = cmd_live && group == cell_monitor_pkg::GRP_BALANCE;
  // A reset command restores the same defaults as the reset pin
  wire soft_reset = reset || hit_reset;

  // Switch pair for one measurement code: cell n closes Sn1 and S(n+1)2,
  // offset closes S(n+1)1 and S(n+1)2, index 5 wraps to 0
  function automatic cell_monitor_pkg::switch_pair_s
      switch_pair(input logic [2:0] sel);
    cell_monitor_pkg::switch_pair_s pair;
    logic [2:0] cell_num;
    logic [2:0] below;
    pair = '0;
    cell_num = {1'b0, sel[1:0]} + 3'h1;
    below = (cell_num == 3'h4) ? 3'h0 : cell_num + 3'h1;
    pair.lower[below] = 1'b1;
    if (sel[cell_monitor_pkg::OFFSET_BIT]) begin
      pair.upper[below] = 1'b1;
    end else begin
      pair.upper[cell_num] = 1'b1;
    end
    return pair;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Latched group settings

  logic [2:0] cell_sel;
  logic [2:0] fet_bits;
  logic route;
  logic reg_5v;
  logic pd;
  logic [cell_monitor_pkg::CELLS-1:0] balance;

  logic charger_s;
  logic dis_ovr_s;
  logic chg_ovr_s;
  assign charger_s = pins.charger_present_in;
  assign dis_ovr_s = pins.discharge_override_in;
  assign chg_ovr_s = pins.charge_override_in;

  wire mux_is_ground = code == cell_monitor_pkg::MUX_GROUND_A
    || code == cell_monitor_pkg::MUX_GROUND_B
    || code == cell_monitor_pkg::MUX_GROUND_C;
  wire [2:0] bal_index = (code >= cell_monitor_pkg::BAL_ALIAS_BASE)
    ? code - cell_monitor_pkg::BAL_ALIAS_BASE : code - 3'h1;
  wire bal_close = code != cell_monitor_pkg::BAL_ALL_OPEN;
  wire [cell_monitor_pkg::CELLS-1:0] bal_bit =
    bal_close ? 4'h1 << bal_index[1:0] : 4'h0;

  wire reg_is_33 = code == cell_monitor_pkg::REG_33_A
    || code == cell_monitor_pkg::REG_33_B;
  wire reg_is_50 = code == cell_monitor_pkg::REG_50;
  wire reg_is_pd = code == cell_monitor_pkg::REG_POWER_DOWN;

  always_ff @(posedge clock) begin
    if (soft_reset) begin
      cell_sel <= cell_monitor_pkg::CELL_SEL_RESET;
      fet_bits <= cell_monitor_pkg::FET_RESET;
      route <= 1'b0;
      reg_5v <= 1'b0;
      balance <= cell_monitor_pkg::BAL_RESET;
    end else begin
      if (hit_cell) begin
        cell_sel <= code;
      end
      if (hit_fet) begin
        fet_bits <= code;
      end
      if (hit_mux && code == cell_monitor_pkg::MUX_ROUTE) begin
        route <= 1'b1;
      end else if (hit_mux && mux_is_ground) begin
        route <= 1'b0;
      end
      if (hit_reg && reg_is_33) begin
        reg_5v <= 1'b0;
      end else if (hit_reg && reg_is_50) begin
        reg_5v <= 1'b1;
      end
      if (hit_bal && !bal_close) begin
        balance <= '0;
      end else if (hit_bal) begin
        balance <= balance | bal_bit;
      end
    end
  end

  // Power down: entered by command unless a charger is present, left
  // when a charger revives the regulator or a 3.3V or 5V regulator command arrives
  always_ff @(posedge clock) begin
    if (soft_reset || charger_s) begin
      pd <= 1'b0;
    end else if (hit_reg && reg_is_pd) begin
      pd <= 1'b1;
    end else if (hit_reg && (reg_is_33 || reg_is_50)) begin
      pd <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage: every output is a flop

  cell_monitor_pkg::switch_pair_s pair_now;
  assign pair_now = switch_pair(cell_sel);

  // Overrides sit after the latch, so serial traffic cannot mask them
  wire next_charge = !fet_bits[cell_monitor_pkg::FET_CHARGE_BIT]
    || pd || chg_ovr_s;
  wire next_discharge = !fet_bits[cell_monitor_pkg::FET_DISCHARGE_BIT]
    || pd || dis_ovr_s;
  wire next_precharge = !fet_bits[cell_monitor_pkg::FET_PRECHARGE_BIT]
    || pd || chg_ovr_s;
  // Switches close only while the output routes and power is up
  wire next_detect = route && !pd;
  wire [cell_monitor_pkg::SWITCHES-1:0] next_upper =
    next_detect ? pair_now.upper : '0;
  wire [cell_monitor_pkg::SWITCHES-1:0] next_lower =
    next_detect ? pair_now.lower : '0;

  always_ff @(posedge clock) begin
    if (reset) begin
      charge_fet_drive <= 1'b1;
      discharge_fet_drive <= 1'b1;
      precharge_fet_drive <= 1'b1;
      cell_switch_upper <= '0;
      cell_switch_lower <= '0;
      mux_route_measurement <= 1'b0;
      detect_enable <= 1'b0;
      regulator_enable <= 1'b1;
      regulator_5v_sel <= 1'b0;
      power_down <= 1'b0;
      charger_pulldown <= 1'b0;
      balance_switch <= '0;
      command_latch <= '0;
    end else begin
      charge_fet_drive <= next_charge;
      discharge_fet_drive <= next_discharge;
      precharge_fet_drive <= next_precharge;
      cell_switch_upper <= next_upper;
      cell_switch_lower <= next_lower;
      mux_route_measurement <= next_detect;
      detect_enable <= next_detect;
      regulator_enable <= !pd;
      regulator_5v_sel <= reg_5v && !pd;
      power_down <= pd;
      charger_pulldown <= pd;
      balance_switch <= pd ? '0 : balance;
      if (cmd_strobe) begin
        command_latch <= shift_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_shift_gated;
    @(posedge clock) disable iff (reset)
      pins.select_n |=> $stable(shift_reg);
  endproperty
  a_shift_gated: assert property (p_shift_gated)
    else $error("Shift register moved while select was high");

  property p_shift_bit;
    @(posedge clock) disable iff (reset)
      shift_take |=> shift_reg[CMD_BITS-1] == $past(pins.serial_data_in)
        && shift_reg[CMD_BITS-2:0] == $past(shift_reg[CMD_BITS-1:1]);
  endproperty
  a_shift_bit: assert property (p_shift_bit)
    else $error("Shifted bit not taken at the top");

  property p_latch;
    @(posedge clock) disable iff (reset)
      cmd_strobe |=> command_latch == $past(shift_reg);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Command latch did not copy the shift register");

  property p_fet_cmd;
    @(posedge clock) disable iff (reset)
      hit_fet && !charger_s && !dis_ovr_s && !chg_ovr_s
        ##1 !dis_ovr_s && !chg_ovr_s && !pd
        |=> charge_fet_drive == !$past(code[2], 2)
          && discharge_fet_drive == !$past(code[1], 2)
          && precharge_fet_drive == !$past(code[0], 2);
  endproperty
  a_fet_cmd: assert property (p_fet_cmd)
    else $error("FET outputs do not follow the FET command");

  property p_reset_defaults;
    @(posedge clock) disable iff (reset)
      $fell(reset) |-> charge_fet_drive && discharge_fet_drive
        && precharge_fet_drive && cell_switch_upper == '0
        && balance_switch == '0 && regulator_enable
        && !regulator_5v_sel;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Reset defaults not shown after reset");

  property p_ground_saves;
    @(posedge clock) disable iff (reset)
      !route || pd |=> !detect_enable && !mux_route_measurement
        && cell_switch_upper == '0 && cell_switch_lower == '0;
  endproperty
  a_ground_saves: assert property (p_ground_saves)
    else $error("Switches closed while the output is grounded");

  property p_regulator_50;
    @(posedge clock) disable iff (reset)
      hit_reg && reg_is_50 && !charger_s ##1 !pd |=> regulator_5v_sel;
  endproperty
  a_regulator_50: assert property (p_regulator_50)
    else $error("Five volt select not taken");

  property p_charger_blocks;
    @(posedge clock) disable iff (reset)
      charger_s |=> !pd ##1 !power_down;
  endproperty
  a_charger_blocks: assert property (p_charger_blocks)
    else $error("Power down entered with charger present");

  property p_pd_fets;
    @(posedge clock) disable iff (reset)
      pd |=> charge_fet_drive && discharge_fet_drive
        && precharge_fet_drive && !regulator_enable && charger_pulldown;
  endproperty
  a_pd_fets: assert property (p_pd_fets)
    else $error("Power down did not force FETs and regulator");

  property p_balance_open;
    @(posedge clock) disable iff (reset)
      hit_bal && !bal_close |=> balance == '0;
  endproperty
  a_balance_open: assert property (p_balance_open)
    else $error("Balance all-open command left a switch closed");

  property p_balance_keep;
    @(posedge clock) disable iff (reset)
      hit_bal |=> (balance & $past(balance)) == $past(balance)
        || !$past(bal_close);
  endproperty
  a_balance_keep: assert property (p_balance_keep)
    else $error("Balance switch dropped by a later command");

  property p_dis_override;
    @(posedge clock) disable iff (reset)
      dis_ovr_s |=> discharge_fet_drive;
  endproperty
  a_dis_override: assert property (p_dis_override)
    else $error("Discharge override not honoured");

  property p_chg_override;
    @(posedge clock) disable iff (reset)
      chg_ovr_s |=> charge_fet_drive && precharge_fet_drive;
  endproperty
  a_chg_override: assert property (p_chg_override)
    else $error("Charge override not honoured");

  property p_group_hold;
    @(posedge clock) disable iff (reset)
      !hit_fet && !soft_reset |=> $stable(fet_bits);
  endproperty
  a_group_hold: assert property (p_group_hold)
    else $error("FET setting changed without a FET command");

endmodule
`default_nettype wire

// File: hw/pin_synchroniser.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_synchroniser #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] levels
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_levels = (agree & stage3) | (~agree & levels);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_synchroniser needs WIDTH of at least 1");
  end

  // Stage 1 feeds stage 2 only; the filter looks at stages 2 and 3
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      levels <= RESET_VALUE;
    end else begin
      stage1 <= pins;
      stage2 <= stage1;
      stage3 <= stage2;
      levels <= next_levels;
    end
  end

endmodule
`default_nettype wire

// File: shared/cell_monitor_pkg.sv
// Shared constants and types for the cell monitor command decoder
`default_nettype none
package cell_monitor_pkg;

  localparam int CMD_WIDTH = 6;
  localparam int CELLS = 4;
  localparam int SWITCHES = 5;

  // Command word fields
  localparam int GROUP_MSB = 5;
  localparam int GROUP_LSB = 3;
  localparam int CODE_MSB = 2;
  localparam int CODE_LSB = 0;

  // Function groups (register offsets)
  localparam logic [2:0] GRP_RESET = 3'h0;
  localparam logic [2:0] GRP_CELL_MON = 3'h1;
  localparam logic [2:0] GRP_FET = 3'h2;
  localparam logic [2:0] GRP_MUX = 3'h3;
  localparam logic [2:0] GRP_REG = 3'h4;
  localparam logic [2:0] GRP_BALANCE = 3'h5;

  // Fet_drive_control bit positions inside the code (low means driven high)
  localparam int FET_CHARGE_BIT = 2;
  localparam int FET_DISCHARGE_BIT = 1;
  localparam int FET_PRECHARGE_BIT = 0;
  localparam logic [2:0] FET_RESET = 3'h0;

  // Multiplexer codes
  localparam logic [2:0] MUX_GROUND_A = 3'h0;
  localparam logic [2:0] MUX_ROUTE = 3'h1;
  localparam logic [2:0] MUX_GROUND_B = 3'h2;
  localparam logic [2:0] MUX_GROUND_C = 3'h3;

  // Regulator codes
  localparam logic [2:0] REG_33_A = 3'h0;
  localparam logic [2:0] REG_POWER_DOWN = 3'h1;
  localparam logic [2:0] REG_50 = 3'h2;
  localparam logic [2:0] REG_33_B = 3'h3;

  // Cell measurement select: bit 2 picks offset, bits 1:0 pick the cell
  localparam int OFFSET_BIT = 2;
  localparam logic [2:0] CELL_SEL_RESET = 3'h0;

  // Balance codes
  localparam logic [2:0] BAL_ALL_OPEN = 3'h0;
  localparam logic [2:0] BAL_FIRST_HIGH = 3'h4;
  localparam logic [2:0] BAL_ALIAS_BASE = 3'h5;
  localparam logic [3:0] BAL_RESET = 4'h0;

  // Pins from the host side, all outside the clock domain
  typedef struct packed {
    logic select_n;
    logic shift_clock;
    logic serial_data_in;
    logic discharge_override_in;
    logic charge_override_in;
    logic charger_present_in;
  } pins_s;

  // Idle levels of the pins while reset is applied
  localparam pins_s PINS_IDLE = '{select_n: 1'b1, default: 1'b0};

  // One switch pair of the measurement circuit, index 0..4 per row
  typedef struct packed {
    logic [SWITCHES-1:0] upper;
    logic [SWITCHES-1:0] lower;
  } switch_pair_s;

endpackage
`default_nettype wire

// File: verification/serial_host_model.sv
// Host model that shifts command words into the serial port
`default_nettype none
module serial_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Command request from the bench
  input wire logic start,
  input wire logic [11:0] word,
  input wire logic [3:0] bit_count,
  output logic busy,
  // Serial port pins
  output logic select_n,
  output logic shift_clock,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    busy = 1'b0;
    select_n = 1'b1;
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  // Half of a 160 ns link period at the 20 ns system clock
  task automatic half_period();
    repeat (4) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Link clock runs only inside a frame and rests low between frames
  always begin
    @(posedge clock);
    if (start && !busy && !reset) begin
      busy <= 1'b1;
      select_n <= 1'b0;
      half_period();
      for (int i = 0; i < bit_count; i++) begin
        serial_data_in <= word[i];
        half_period();
        shift_clock <= 1'b1;
        half_period();
        shift_clock <= 1'b0;
      end
      half_period();
      select_n <= 1'b1;
      // Released data line shows the inverse, never a stale level
      serial_data_in <= ~serial_data_in;
      half_period();
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/test_cell_monitor_serial_command_decoder.sv
// Self-checking bench for the cell monitor command decoder
`default_nettype none
module test_cell_monitor_serial_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, reset, start, busy, select_n, shift_clock, serial_data_in;
  logic discharge_override_in, charge_override_in, charger_present_in;
  logic charge_fet_drive, discharge_fet_drive, precharge_fet_drive;
  logic mux_route_measurement, detect_enable, regulator_enable;
  logic regulator_5v_sel, power_down, charger_pulldown;
  logic [cell_monitor_pkg::SWITCHES-1:0] cell_switch_upper;
  logic [cell_monitor_pkg::SWITCHES-1:0] cell_switch_lower;
  logic [cell_monitor_pkg::CELLS-1:0] balance_switch;
  logic [cell_monitor_pkg::CMD_WIDTH-1:0] command_latch;
  logic [11:0] word;
  logic [3:0] bit_count;
  logic [2:0] bal_code [0:6] = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h0, 3'h5, 3'h7};
  logic [3:0] bal_exp [0:6] = '{4'h1, 4'h5, 4'hd, 4'hf, 4'h0, 4'h1, 4'h5};
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;

  cell_monitor_serial_command_decoder u_dut (.clock, .reset, .select_n,
    .shift_clock, .serial_data_in, .discharge_override_in,
    .charge_override_in, .charger_present_in, .charge_fet_drive,
    .discharge_fet_drive, .precharge_fet_drive, .cell_switch_upper,
    .cell_switch_lower, .mux_route_measurement, .detect_enable,
    .regulator_enable, .regulator_5v_sel, .power_down, .charger_pulldown,
    .balance_switch, .command_latch);

  serial_host_model u_host (.clock, .reset, .start, .word, .bit_count,
    .busy, .select_n, .shift_clock, .serial_data_in);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang is cut short well above the roughly 8000 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs land 5-6 clocks after a pin edge; 8 leaves margin
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask

  task automatic send(input logic [11:0] w, input logic [3:0] count);
    word <= w;
    bit_count <= count;
    start <= 1'b1;
    @(posedge clock);
    while (!busy) @(posedge clock);
    start <= 1'b0;
    while (busy) @(posedge clock);
    settle();
  endtask

  task automatic cmd(input logic [2:0] grp, input logic [2:0] code);
    send({6'h00, grp, code}, 4'h6);
  endtask

  function automatic logic [15:0] fets();
    return {13'h0000, charge_fet_drive, discharge_fet_drive,
      precharge_fet_drive};
  endfunction

  function automatic logic [15:0] regs();
    return {12'h000, regulator_enable, regulator_5v_sel, power_down,
      charger_pulldown};
  endfunction

  task automatic check_defaults();
    check(fets(), 16'h0007);
    check(16'({cell_switch_upper, cell_switch_lower, mux_route_measurement,
      detect_enable}), 16'h0000);
    check(regs(), 16'h0008);
    check(16'(balance_switch), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    start = 1'b0;
    word = 12'h000;
    bit_count = 4'h0;
    discharge_override_in = 1'b0;
    charge_override_in = 1'b0;
    charger_present_in = 1'b0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    settle();
    check_defaults();
    // Every FET code, and the word order on the wire
    for (int c = 0; c < 8; c++) begin
      cmd(cell_monitor_pkg::GRP_FET, 3'(c));
      check(fets(), {13'h0000, ~3'(c)});
      check(16'(command_latch), {10'h000, 3'h2, 3'(c)});
    end
    discharge_override_in <= 1'b1;
    settle();
    check(fets(), 16'h0002);
    discharge_override_in <= 1'b0;
    charge_override_in <= 1'b1;
    settle();
    check(fets(), 16'h0005);
    cmd(cell_monitor_pkg::GRP_FET, 3'h7);
    check(fets(), 16'h0005);
    charge_override_in <= 1'b0;
    settle();
    check(fets(), 16'h0000);
    // Measurement switch pairs for every cell and offset code
    cmd(cell_monitor_pkg::GRP_MUX, cell_monitor_pkg::MUX_ROUTE);
    // Analog output needs its settling time before it is trusted
    repeat (5000) @(posedge clock);
    for (int c = 0; c < 8; c++) begin
      cmd(cell_monitor_pkg::GRP_CELL_MON, 3'(c));
      n = (c & 3) + 1;
      check(16'({cell_switch_upper, cell_switch_lower}),
        {6'h00, 5'(c > 3 ? 1 << ((n + 1) % 5) : 1 << n),
        5'(1 << ((n + 1) % 5))});
      check(16'({mux_route_measurement, detect_enable}), 16'h0003);
    end
    cmd(cell_monitor_pkg::GRP_MUX, 3'h4);
    check(16'(mux_route_measurement), 16'h0001);
    cmd(3'h6, 3'h0);
    check(16'({charge_fet_drive, discharge_fet_drive, precharge_fet_drive,
      mux_route_measurement}), 16'h0001);
    for (int c = 0; c < 4; c++) begin
      if (c != 1) begin
        cmd(cell_monitor_pkg::GRP_MUX, cell_monitor_pkg::MUX_ROUTE);
        cmd(cell_monitor_pkg::GRP_MUX, 3'(c));
        check(16'({cell_switch_upper, cell_switch_lower,
          mux_route_measurement, detect_enable}), 16'h0000);
      end
    end
    // Regulator settings and the power down entry and exit
    // Only the digital regulator, power and FET outputs are checked; the rail's settling is analog
    cmd(cell_monitor_pkg::GRP_REG, cell_monitor_pkg::REG_50);
    check(regs(), 16'h000c);
    cmd(cell_monitor_pkg::GRP_REG, 3'h5);
    check(regs(), 16'h000c);
    cmd(cell_monitor_pkg::GRP_REG, cell_monitor_pkg::REG_33_B);
    check(regs(), 16'h0008);
    charger_present_in <= 1'b1;
    cmd(cell_monitor_pkg::GRP_REG, cell_monitor_pkg::REG_POWER_DOWN);
    check(regs(), 16'h0008);
    charger_present_in <= 1'b0;
    cmd(cell_monitor_pkg::GRP_REG, cell_monitor_pkg::REG_POWER_DOWN);
    check(regs(), 16'h0003);
    check(fets(), 16'h0007);
    cmd(cell_monitor_pkg::GRP_FET, 3'h7);
    check(fets(), 16'h0007);
    cmd(cell_monitor_pkg::GRP_REG, cell_monitor_pkg::REG_33_A);
    check(regs(), 16'h0008);
    // Balance switches build up a set over several commands
    for (int i = 0; i < 7; i++) begin
      cmd(cell_monitor_pkg::GRP_BALANCE, bal_code[i]);
      check(16'(balance_switch), 16'(bal_exp[i]));
    end
    // Eight bits in one frame: only the last six count
    send({4'h0, 3'h5, 3'h4, 2'h3}, 4'h8);
    check(16'(command_latch), 16'h002c);
    check(16'(balance_switch), 16'h000d);
    cmd(cell_monitor_pkg::GRP_RESET, 3'h0);
    check_defaults();
    end_sim();
  end
endmodule
`default_nettype wire
